// [aib_device.sv]
// Carrier-side bus slave for up to four analog converter modules
// Assumes jumper pins are asynchronous and the master holds each strobe
// until it sees the one-cycle ready pulse
//
// Implementation choices: the register offsets and the APB interface to the registers.
`include "aib_cfg.svh"
module aib_device
    import aib_pkg::*;
(
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RST_N,
    // Board straps
    input wire logic [4:0] I_UNIT_ADDRESS_JUMPERS,
    input wire logic [`AIB_MODS-1:0] I_FITTED,
    // Converter values, module 0 channel 0 lowest
    input wire logic [`AIB_MODS*`AIB_CHANS*`AIB_VAL_W-1:0] I_CHAN_VALS,
    // Per-module sample/hold indicators
    output logic [`AIB_MODS-1:0] O_TRACK_STATE_INDICATOR,
    // Backplane
    aib_if.dev bus
);
    localparam int MOD_VALS = `AIB_CHANS * `AIB_VAL_W;

    logic [4:0] jmp1_q;
    logic [4:0] jmp2_q;
    logic [4:0] jmp3_q;
    logic [4:0] unit_q;
    logic [`AIB_ACC_W-1:0] acc_q;
    logic [`AIB_ACC_W:0] acc_sum;
    logic tick_q;
    logic top_hit;
    logic jmp_hit;
    logic unit_hit;
    logic word_hit;
    logic [1:0] mod_sel;
    logic [`AIB_MODS-1:0] sel_oh;
    logic strobe;
    logic take_wr;
    logic take_rd;
    logic rdy_q;
    aib_word_t rdata_q;
    aib_word_t rd_word;
    aib_word_t results [`AIB_MODS];
    logic [`AIB_MODS-1:0] load;
    logic [`AIB_MODS-1:0] hold;

    // Jumper pins: three stages, a change counts once the last two agree
    always_ff @(posedge I_CLOCK)
    begin
        if (!I_RST_N)
        begin
            jmp1_q <= `AIB_JMP_RST;
            jmp2_q <= `AIB_JMP_RST;
            jmp3_q <= `AIB_JMP_RST;
        end
        else
        begin
            jmp1_q <= I_UNIT_ADDRESS_JUMPERS;
            jmp2_q <= jmp1_q;
            jmp3_q <= jmp2_q;
        end
    end

    // Fitted jumper pulls low, so the pin level is the address bit
    always_ff @(posedge I_CLOCK)
    begin
        if (!I_RST_N)
        begin
            unit_q <= `AIB_UNIT_RST;
        end
        else if (jmp2_q == jmp3_q)
        begin
            unit_q <= jmp3_q;
        end
    end

    // Phase accumulator gives the module clock rate as an enable pulse;
    // 10 MHz is no integer multiple, so ticks jitter by one system cycle
    assign acc_sum = {1'b0, acc_q} + (`AIB_ACC_W+1)'(`AIB_ACC_INC);

    always_ff @(posedge I_CLOCK)
    begin
        if (!I_RST_N)
        begin
            acc_q <= '0;
        end
        else
        begin
            acc_q <= acc_sum[`AIB_ACC_W-1:0];
        end
    end

    // The carry out of the accumulator is the module clock enable
    always_ff @(posedge I_CLOCK)
    begin
        if (!I_RST_N)
        begin
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= acc_sum[`AIB_ACC_W];
        end
    end

    // Address decode: top bits fixed, jumpers, any even low byte in the block
    always_comb
    begin
        top_hit = (bus.addr[15:13] == `AIB_UNIT_TOP);
        jmp_hit = (bus.addr[12:8] == unit_q);
        unit_hit = top_hit && jmp_hit;
        mod_sel = bus.addr[2:1];
        word_hit = unit_hit && !bus.addr[0];
    end

    // One-hot socket select keeps each module load a single gate
    always_comb
    begin
        sel_oh = '0;
        sel_oh[mod_sel] = 1'b1;
    end

    // Writes to a missing module are acknowledged but change nothing;
    // a write wins when both strobes are up
    always_comb
    begin
        strobe = (bus.wr || bus.rd) && word_hit && !rdy_q;
        take_wr = strobe && bus.wr;
        take_rd = strobe && !bus.wr;
    end

    generate
        for (genvar m = 0; m < `AIB_MODS; m++)
        begin : g_mod
            assign load[m] = take_wr && sel_oh[m]
                && I_FITTED[m];

            aib_conv u_conv (
                .i_clk (I_CLOCK),
                .i_rst_n (I_RST_N),
                .i_tick (tick_q),
                .i_load (load[m]),
                .i_word (bus.wdata),
                .i_vals (I_CHAN_VALS[m*MOD_VALS +: MOD_VALS]),
                .o_result (results[m]),
                .o_hold (hold[m])
            );
        end
    endgenerate

    // Ready is a single pulse; the guard on rdy_q stops a held strobe
    // from being taken twice
    always_ff @(posedge I_CLOCK)
    begin
        if (!I_RST_N)
        begin
            rdy_q <= 1'b0;
        end
        else
        begin
            rdy_q <= take_wr || take_rd;
        end
    end

    // An empty socket reads as permanently pending
    always_comb
    begin
        if (I_FITTED[mod_sel])
        begin
            rd_word = results[mod_sel];
        end
        else
        begin
            rd_word = `AIB_UNFITTED_WORD;
        end
    end

    // Read data holds until the next read is taken
    always_ff @(posedge I_CLOCK)
    begin
        if (!I_RST_N)
        begin
            rdata_q <= `AIB_RDATA_RST;
        end
        else if (take_rd)
        begin
            rdata_q <= rd_word;
        end
    end

    // Indicator re-timed so the pin comes straight from a flip-flop;
    // it trails the hold state by one system cycle
    always_ff @(posedge I_CLOCK)
    begin
        if (!I_RST_N)
        begin
            O_TRACK_STATE_INDICATOR <= `AIB_IND_RST;
        end
        else
        begin
            O_TRACK_STATE_INDICATOR <= hold;
        end
    end

    assign bus.rdy = rdy_q;
    assign bus.rdata = rdata_q;
endmodule // aib_device

// [aib_cfg.svh]
// Constants for the analog input bus slave and its controller
// Assumes a 10 MHz system clock shared by both ends of the backplane
`ifndef AIB_CFG_SVH
`define AIB_CFG_SVH

`define AIB_CLK_HZ 64'd10000000
`define AIB_MODCLK_HZ 64'd2457600
`define AIB_ACC_W 24
`define AIB_ACC_INC ((`AIB_MODCLK_HZ * (64'd1 << 24)) / `AIB_CLK_HZ)
`define AIB_CONV_TIME_NS 64'd40000
`define AIB_CONV_TICKS ((`AIB_CONV_TIME_NS * `AIB_MODCLK_HZ) / 64'd1000000000)
`define AIB_CNT_W 7

`define AIB_UNIT_TOP 3'h7
`define AIB_MODS 4
`define AIB_CHANS 8
`define AIB_VAL_W 12
`define AIB_CW_CH_LSB 0
`define AIB_CW_TRACK_BIT 5
`define AIB_RD_PEND_BIT 15
`define AIB_UNFITTED_WORD 16'h8000
`define AIB_JMP_RST 5'h00
`define AIB_UNIT_RST 5'h1F
`define AIB_RDATA_RST 16'h0000
`define AIB_IND_RST 4'hF

`define AIB_REG_BASE 8'h00
`define AIB_REG_CMD 8'h04
`define AIB_REG_STAT 8'h08
`define AIB_BASE_RST 5'h08
`define AIB_CMD_CH_LSB 0
`define AIB_CMD_TRACK_BIT 5
`define AIB_CMD_MOD_LSB 8
`define AIB_CMD_READ_BIT 12
`define AIB_ST_BUSY_BIT 16

`endif

// [aib_pkg.sv]
// Types shared by both ends of the analog input bus
// Assumes aib_cfg.svh holds the numeric constants
package aib_pkg;
    typedef logic [15:0] aib_word_t;
    typedef enum logic {AIB_H_IDLE, AIB_H_REQ} aib_hstate_t;
endpackage

// [aib_if.sv]
// Backplane link between the bus master and the analog input carrier
// Assumes both ends run on the same clock; data paths are split per direction
interface aib_if;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic wr;
    logic rd;
    logic rdy;
    modport dev (input addr, input wdata, input wr, input rd,
        output rdata, output rdy);
    modport host (output addr, output wdata, output wr, output rd,
        input rdata, input rdy);
endinterface

// [aib_conv.sv]
// One converter module: channel select, track state and conversion timer
// Assumes i_tick is the module clock enable and values are same-clock logic
`include "aib_cfg.svh"
module aib_conv
    import aib_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Control
    input wire logic i_tick,
    input wire logic i_load,
    input wire aib_word_t i_word,
    // Converter inputs, channel 0 lowest
    input wire logic [`AIB_CHANS*`AIB_VAL_W-1:0] i_vals,
    // Results
    output aib_word_t o_result,
    output logic o_hold
);
    logic [2:0] ch_q;
    logic pend_q;
    logic [`AIB_VAL_W-1:0] val_q;
    logic [`AIB_CNT_W-1:0] cnt_q;
    logic hold_q;

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            ch_q <= 3'h0;
            hold_q <= 1'b1;
        end
        else if (i_load)
        begin
            ch_q <= i_word[`AIB_CW_CH_LSB +: 3];
            hold_q <= ~i_word[`AIB_CW_TRACK_BIT];
        end
    end

    // Timer counts module clock ticks, so it rounds down to stay inside 40 us
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            pend_q <= 1'b1;
            cnt_q <= '0;
            val_q <= '0;
        end
        else if (i_load)
        begin
            pend_q <= 1'b1;
            cnt_q <= '0;
        end
        else if (pend_q && i_tick)
        begin
            if (cnt_q == `AIB_CNT_W'(`AIB_CONV_TICKS - 1))
            begin
                pend_q <= 1'b0;
                val_q <= i_vals[ch_q*`AIB_VAL_W +: `AIB_VAL_W];
            end
            else
            begin
                cnt_q <= cnt_q + `AIB_CNT_W'(1);
            end
        end
    end

    assign o_result = {pend_q, 3'h0, val_q};
    assign o_hold = hold_q;
endmodule // aib_conv

// [aib_host.sv]
// Bus master end: APB registers take orders and issue backplane cycles
// Assumes the device answers each strobe with a one-cycle ready pulse
`include "aib_cfg.svh"
module aib_host
    import aib_pkg::*;
(
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RST_N,
    // APB slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // Backplane
    aib_if.host bus
);
    aib_hstate_t state_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [4:0] base_q;
    aib_word_t result_q;
    logic [15:0] addr_q;
    aib_word_t wdata_q;
    logic wr_q;
    logic rd_q;
    logic acc;
    logic known;
    logic cmd_go;

    assign acc = I_PSEL && I_PENABLE;
    assign known = (I_PADDR == `AIB_REG_BASE) || (I_PADDR == `AIB_REG_CMD)
        || (I_PADDR == `AIB_REG_STAT);
    // Write takes effect at the edge where ready is seen high
    assign cmd_go = acc && pready_q && I_PWRITE
        && (I_PADDR == `AIB_REG_CMD) && (state_q == AIB_H_IDLE);

    // One wait state so read data can come from a flip-flop
    always_ff @(posedge I_CLOCK)
    begin
        if (!I_RST_N)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pready_q <= acc && !pready_q;
            pslverr_q <= acc && !pready_q && !known;
            if (acc && !pready_q && !I_PWRITE)
            begin
                unique case (I_PADDR)
                    `AIB_REG_BASE: prdata_q <= {27'h0, base_q};
                    `AIB_REG_STAT: prdata_q <= {15'h0,
                        state_q != AIB_H_IDLE, result_q};
                    default: prdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge I_CLOCK)
    begin
        if (!I_RST_N)
        begin
            base_q <= `AIB_BASE_RST;
        end
        else if (acc && pready_q && I_PWRITE
            && (I_PADDR == `AIB_REG_BASE))
        begin
            base_q <= I_PWDATA[4:0];
        end
    end

    // A command written while busy is dropped; software polls busy first
    always_ff @(posedge I_CLOCK)
    begin
        if (!I_RST_N)
        begin
            state_q <= AIB_H_IDLE;
            addr_q <= 16'h0000;
            wdata_q <= 16'h0000;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            result_q <= `AIB_UNFITTED_WORD;
        end
        else
        begin
            unique case (state_q)
                AIB_H_IDLE:
                begin
                    if (cmd_go)
                    begin
                        addr_q <= {`AIB_UNIT_TOP, base_q, 5'h00,
                            I_PWDATA[`AIB_CMD_MOD_LSB +: 2], 1'b0};
                        wdata_q <= {10'h000,
                            I_PWDATA[`AIB_CMD_TRACK_BIT], 2'h0,
                            I_PWDATA[`AIB_CMD_CH_LSB +: 3]};
                        rd_q <= I_PWDATA[`AIB_CMD_READ_BIT];
                        wr_q <= ~I_PWDATA[`AIB_CMD_READ_BIT];
                        state_q <= AIB_H_REQ;
                    end
                end
                AIB_H_REQ:
                begin
                    if (bus.rdy)
                    begin
                        wr_q <= 1'b0;
                        rd_q <= 1'b0;
                        state_q <= AIB_H_IDLE;
                        if (rd_q)
                        begin
                            result_q <= {bus.rdata[15], 3'h0,
                                bus.rdata[11:0]};
                        end
                    end
                end
            endcase
        end
    end

    assign O_PREADY = pready_q;
    assign O_PSLVERR = pslverr_q;
    assign O_PRDATA = prdata_q;
    assign bus.addr = addr_q;
    assign bus.wdata = wdata_q;
    assign bus.wr = wr_q;
    assign bus.rd = rd_q;
endmodule // aib_host

// [aib_chk.sv]
// Backplane checks between the host end and the carrier end
// Assumes one clock and jumper pins held still around traffic
module aib_chk
(
    // Clock, reset and straps
    input wire logic I_CLOCK,
    input wire logic I_RST_N,
    input wire logic [4:0] I_UNIT_ADDRESS_JUMPERS,
    // Backplane
    input wire logic [15:0] addr,
    input wire logic [15:0] rdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic rdy
);
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!I_RST_N);

    a_rdy_pulse: assert property (rdy |=> !rdy)
        else $error("ready longer than one cycle");
    a_rdy_cause: assert property (
        rdy |-> $past(wr || rd) && !$past(rdy))
        else $error("ready without a strobe");
    a_top_fixed: assert property (
        rdy |-> $past(addr[15:13]) == 3'h7)
        else $error("answer with top bits not all one");
    a_unit_match: assert property (
        rdy |-> $past(addr[12:8]) == $past(I_UNIT_ADDRESS_JUMPERS))
        else $error("answer to a foreign unit address");
    a_block_answer: assert property (
        (wr || rd) && !rdy && addr[15:13] == 3'h7
        && addr[12:8] == I_UNIT_ADDRESS_JUMPERS && !addr[0] |=> rdy)
        else $error("own address not answered in one cycle");
    a_even_only: assert property (rdy |-> !$past(addr[0]))
        else $error("odd address answered");
    a_rdata_holds: assert property ($changed(rdata) |-> rdy && rd)
        else $error("read data moved outside a read");
    a_strobe_release: assert property (rdy |=> !(wr || rd))
        else $error("strobe kept after ready");
    a_host_holds: assert property (
        (wr || rd) && !rdy |=> (wr || rd) && $stable(addr))
        else $error("request changed before ready");

    // Write taken, read while pending, read when valid
    c_write: cover property (wr && rdy);
    c_pending: cover property (rd && rdy && rdata[15]);
    c_valid: cover property (rd && rdy && !rdata[15]);
endmodule // aib_chk

// [test_analog_input_bus_slave.sv]
// Bench for host and carrier joined over the backplane interface
// Assumes a 10 MHz clock; APB master and reference model live here
module test_analog_input_bus_slave;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0;
    logic rst_n = 0;
    logic [4:0] jmp = 5'h08;
    logic [3:0] fit = 4'hB;
    logic [383:0] vals_bus = '0;
    logic psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic [3:0] ind;
    logic [3:0] exp_ind;
    logic [11:0] vals[32];
    int mdl_ch[4];
    logic [31:0] exp_q[$];
    int error_cnt = 0, num_checks = 0, cyc = 0;

    aib_if aib_if_inst();
    aib_device aib_device_inst (.I_CLOCK(clk), .I_RST_N(rst_n),
        .I_UNIT_ADDRESS_JUMPERS(jmp), .I_FITTED(fit),
        .I_CHAN_VALS(vals_bus), .O_TRACK_STATE_INDICATOR(ind),
        .bus(aib_if_inst));
    aib_host aib_host_inst (.I_CLOCK(clk), .I_RST_N(rst_n), .I_PSEL(psel),
        .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
        .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .bus(aib_if_inst));
    aib_chk aib_chk_inst (.I_CLOCK(clk), .I_RST_N(rst_n),
        .I_UNIT_ADDRESS_JUMPERS(jmp), .addr(aib_if_inst.addr),
        .rdata(aib_if_inst.rdata), .wr(aib_if_inst.wr),
        .rd(aib_if_inst.rd), .rdy(aib_if_inst.rdy));

    initial
    begin
        forever #50 clk = ~clk;
    end

    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Run is about 3500 cycles; the ceiling leaves ample margin
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            error_cnt++;
            $display("mismatch %0t run timed out", $time);
            final_report();
        end
    end

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_ind(input logic [3:0] exp, input string what);
        num_checks++;
        if (ind !== exp)
        begin
            error_cnt++;
            $display("mismatch %0t %s got %h exp %h", $time, what, ind, exp);
        end
    endtask

    // Request held until PREADY is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Ends on PREADY; without it only the bench timeout ends this wait
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Order one backplane cycle, then poll until the host is idle or 30 polls have passed
    task automatic issue(input int m, input int ch, input int smp,
        input int rdop, output logic [31:0] st);
        logic e;
        int n;
        apb(1'b1, 8'h04, 32'(rdop << 12 | m << 8 | smp << 5 | ch), st, e);
        n = 0;
        do
        begin
            apb(1'b0, 8'h08, 32'h0, st, e);
            n++;
        end
        while (st[16] !== 1'b0 && n < 30);
    endtask

    initial
    begin
        logic [31:0] r;
        logic e;
        int m;
        void'($urandom(32'h01767320));
        for (int k = 0; k < 32; k++)
            vals[k] = 12'($urandom());
        vals[0] = 12'h7FF;
        vals[4] = 12'h800;
        vals[9] = 12'h000;
        @(posedge clk);
        jmp <= 5'($urandom());
        for (int k = 0; k < 32; k++)
            vals_bus[k*12 +: 12] <= vals[k];
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        exp_ind = 4'hF;
        chk_ind(exp_ind, "track after reset");
        apb(1'b0, 8'h00, 32'h0, r, e);
        chk_word(r, 32'h08, "base reset");
        apb(1'b1, 8'h00, {27'h0, jmp}, r, e);
        // Each channel once, spread over all four modules; hold mode on the second round
        for (int i = 0; i < 8; i++)
        begin
            m = i % 4;
            issue(m, i, (i < 4), 0, r);
            if (fit[m])
            begin
                exp_ind[m] = (i >= 4);
                mdl_ch[m] = i;
            end
            exp_q.push_back(fit[m] ? {20'h0, vals[m*8+mdl_ch[m]]}
                : 32'h8000);
            chk_ind(exp_ind, "track state");
            issue(m, 0, 0, 1, r);
            if (fit[m])
                chk_word({31'h0, r[15]}, 32'h1, "pending flag");
            else
                chk_word(r, 32'h8000, "unfitted read");
            repeat (400) @(posedge clk);
            issue(m, 0, 0, 1, r);
            chk_word(r, exp_q.pop_front(),
                "result word");
        end
        apb(1'b0, 8'h0C, 32'h0, r, e);
        chk_word({r[31:1], e}, 32'h1, "unmapped read");
        // Foreign unit address: never answered, host stays busy
        apb(1'b1, 8'h00, {27'h0, jmp ^ 5'h01}, r, e);
        issue(0, 3, 0, 0, r);
        chk_word({31'h0, r[16]}, 32'h1, "refused cycle");
        chk_ind(exp_ind, "track after refusal");
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        chk_ind(4'hF, "track after second reset");
        final_report();
    end
endmodule // test_analog_input_bus_slave
